// ==== rtl/doorbell_regs.svh ====
// Timing and field constants for the wireless doorbell controller.
// Assumes a 250 MHz system clock; included by bare name.
`ifndef DOORBELL_REGS_SVH
`define DOORBELL_REGS_SVH
`define DB_CLK_HZ          250_000_000
`define DB_ALERT_MS        5000
`define DB_BLINK_MS        500
`define DB_HOLD_MS         5000
`define DB_ALERT_CYC       ((`DB_CLK_HZ / 1000) * `DB_ALERT_MS)
`define DB_BLINK_CYC       ((`DB_CLK_HZ / 1000) * `DB_BLINK_MS)
`define DB_HOLD_CYC        ((`DB_CLK_HZ / 1000) * `DB_HOLD_MS)
`define DB_RING_CODE       8'h5A
`define DB_PWM_DIV         32'h0000_F424
`endif

// ==== rtl/doorbell_pkg.sv ====
// Types shared by the doorbell controller files.
// Assumes the timing header is compiled alongside.
package doorbell_pkg;
    typedef enum logic [1:0] {TX_SLEEP, TX_SEND, TX_HOLD} tx_state_e;
    typedef struct packed {
        logic       valid;
        logic [7:0] data;
    } msg_s;
endpackage : doorbell_pkg

// ==== rtl/key_sync.sv ====
// Two-stage synchroniser with press and release pulses for a key pin.
// Assumes an active-high key level from outside the clock domain.
`timescale 1ns/1ps
module key_sync (
    // Clock and reset.
    input  wire logic clk,
    input  wire logic rst,
    // Key.
    input  wire logic key_pin,
    output logic      level,
    output logic      press,
    output logic      release_p
);
    logic meta_q;
    logic sync_q;
    logic last_q;

    always_ff @(posedge clk) begin
        if (rst) begin
            meta_q <= 1'b0;
            sync_q <= 1'b0;
            last_q <= 1'b0;
        end else begin
            meta_q <= key_pin;
            sync_q <= meta_q;
            last_q <= sync_q;
        end
    end

    assign level     = sync_q;
    assign press     = sync_q & ~last_q;
    assign release_p = ~sync_q & last_q;
endmodule : key_sync

// ==== rtl/doorbell_ctrl.sv ====
// Transmitter and receiver control logic for a wireless doorbell pair.
// Assumes a radio module that accepts one message per send strobe.
//
// Summary of operation
// - Transmitter sleeps after reset, wakes only on a key press.
// - Transmitter LED turns on when a press is detected.
// - Transmitter LED turns off when release is detected.
// - Each key press sends one ring message, or two if the key is held five seconds.
// - Key held five seconds sends the ring message again.
// - Battery low blinks the transmitter LED for five seconds.
// - Receiver ignores radio data until radio initialisation completes.
// - Ring message starts LED blinking and speaker together.
// - Receiver LED toggles every 500 ms, stops after five seconds.
// - Speaker melody runs five seconds, then stops.
// - Local key press during alert stops LED and speaker immediately.
// - Receiver LED is off once the alert ends.
// - After sending and key release, transmitter sleeps and drops radio supply enable.
// - Melody is PWM; amplifier enable is high while sounding.
`timescale 1ns/1ps
`include "doorbell_regs.svh"
module doorbell_ctrl
    import doorbell_pkg::*;
#(
    parameter int unsigned ALERT_CYC = `DB_ALERT_CYC,
    parameter int unsigned BLINK_CYC = `DB_BLINK_CYC,
    parameter int unsigned HOLD_CYC  = `DB_HOLD_CYC,
    parameter int unsigned PWM_DIV   = `DB_PWM_DIV
) (
    // Clock and reset.
    input  wire logic clk,
    input  wire logic rst,
    // Transmitter side.
    input  wire logic tx_key_pin,
    input  wire logic batt_low_pin,
    input  wire logic tx_send_done,
    output logic      tx_led,
    output logic      tx_radio_pwr_en,
    output msg_s      tx_msg,
    output logic      tx_awake,
    // Receiver side.
    input  wire logic rx_key_pin,
    input  wire logic radio_init_done,
    input  msg_s      rx_msg,
    output logic      rx_led,
    output logic      spk_pwm,
    output logic      amp_en,
    output logic      rx_armed
);
    if (BLINK_CYC == 0 || BLINK_CYC > ALERT_CYC || HOLD_CYC == 0 || PWM_DIV < 2) begin : g_bad_params
        $error("doorbell_ctrl: bad timing parameters");
    end

    // --------------------------------------------------
    // Key, battery and radio-init synchronisers
    // --------------------------------------------------
    logic tx_lvl, tx_press, tx_rel;
    logic rx_lvl, rx_press;
    logic batt_m_q, batt_q, init_m_q, init_q;

    key_sync u_tx_key (.clk(clk), .rst(rst), .key_pin(tx_key_pin),
        .level(tx_lvl), .press(tx_press), .release_p(tx_rel));
    key_sync u_rx_key (.clk(clk), .rst(rst), .key_pin(rx_key_pin),
        .level(rx_lvl), .press(rx_press), .release_p());

    always_ff @(posedge clk) begin
        if (rst) begin
            batt_m_q <= 1'b0;
            batt_q   <= 1'b0;
            init_m_q <= 1'b0;
            init_q   <= 1'b0;
        end else begin
            batt_m_q <= batt_low_pin;
            batt_q   <= batt_m_q;
            init_m_q <= radio_init_done;
            init_q   <= init_m_q;
        end
    end

    // --------------------------------------------------
    // Transmitter
    // --------------------------------------------------
    tx_state_e   tx_state_q;
    logic [31:0] hold_cnt_q;
    logic        resend_done_q;
    logic        batt_last_q;
    logic [31:0] warn_cnt_q;
    logic [31:0] warn_blink_q;
    logic        warn_led_q;

    always_ff @(posedge clk) begin
        if (rst) begin
            tx_state_q      <= TX_SLEEP;
            tx_msg          <= '0;
            tx_radio_pwr_en <= 1'b0;
            hold_cnt_q      <= '0;
            resend_done_q   <= 1'b0;
        end else begin
            tx_msg.valid <= 1'b0;
            if (tx_state_q != TX_SLEEP && !tx_lvl)
                resend_done_q <= 1'b1;
            else if (tx_state_q != TX_SLEEP && !resend_done_q && hold_cnt_q != HOLD_CYC - 1)
                hold_cnt_q <= hold_cnt_q + 32'd1;
            case (tx_state_q)
                TX_SLEEP: begin
                    if (tx_press) begin
                        tx_state_q      <= TX_SEND;
                        tx_radio_pwr_en <= 1'b1;
                        tx_msg.valid    <= 1'b1;
                        tx_msg.data     <= `DB_RING_CODE;
                        hold_cnt_q      <= '0;
                        resend_done_q   <= 1'b0;
                    end
                end
                TX_SEND: begin
                    if (tx_send_done)
                        tx_state_q <= TX_HOLD;
                end
                TX_HOLD: begin
                    if (!tx_lvl) begin
                        tx_state_q      <= TX_SLEEP;
                        tx_radio_pwr_en <= 1'b0;
                    end else if (!resend_done_q && hold_cnt_q == HOLD_CYC - 1) begin
                        tx_state_q    <= TX_SEND;
                        tx_msg.valid  <= 1'b1;
                        resend_done_q <= 1'b1;
                    end
                end
                default: tx_state_q <= TX_SLEEP;
            endcase
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            batt_last_q  <= 1'b0;
            warn_cnt_q   <= '0;
            warn_blink_q <= '0;
            warn_led_q   <= 1'b0;
        end else begin
            batt_last_q <= batt_q;
            if (batt_q && !batt_last_q) begin
                warn_cnt_q   <= ALERT_CYC;
                warn_blink_q <= '0;
                warn_led_q   <= 1'b1;
            end else if (warn_cnt_q != 0) begin
                warn_cnt_q <= warn_cnt_q - 32'd1;
                if (warn_blink_q == BLINK_CYC - 1) begin
                    warn_blink_q <= '0;
                    warn_led_q   <= ~warn_led_q;
                end else begin
                    warn_blink_q <= warn_blink_q + 32'd1;
                end
                if (warn_cnt_q == 32'd1)
                    warn_led_q <= 1'b0;
            end
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            tx_led   <= 1'b0;
            tx_awake <= 1'b0;
        end else begin
            tx_awake <= (tx_state_q != TX_SLEEP);
            tx_led   <= (tx_lvl && !tx_rel) || warn_led_q;
        end
    end

    // --------------------------------------------------
    // Receiver
    // --------------------------------------------------
    logic [31:0] alert_cnt_q;
    logic [31:0] blink_cnt_q;
    logic [31:0] pwm_cnt_q;
    logic        ring_hit;

    assign ring_hit = rx_armed && rx_msg.valid && rx_msg.data == `DB_RING_CODE;

    always_ff @(posedge clk) begin
        if (rst)
            rx_armed <= 1'b0;
        else if (init_q)
            rx_armed <= 1'b1;
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            alert_cnt_q <= '0;
            blink_cnt_q <= '0;
            rx_led      <= 1'b0;
            amp_en      <= 1'b0;
        end else if (rx_press && alert_cnt_q != 0) begin
            alert_cnt_q <= '0;
            rx_led      <= 1'b0;
            amp_en      <= 1'b0;
        end else if (ring_hit) begin
            alert_cnt_q <= ALERT_CYC;
            blink_cnt_q <= '0;
            rx_led      <= 1'b1;
            amp_en      <= 1'b1;
        end else if (alert_cnt_q != 0) begin
            alert_cnt_q <= alert_cnt_q - 32'd1;
            if (alert_cnt_q == 32'd1) begin
                rx_led <= 1'b0;
                amp_en <= 1'b0;
            end else if (blink_cnt_q == BLINK_CYC - 1) begin
                blink_cnt_q <= '0;
                rx_led      <= ~rx_led;
            end else begin
                blink_cnt_q <= blink_cnt_q + 32'd1;
            end
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            pwm_cnt_q <= '0;
            spk_pwm   <= 1'b0;
        end else if (!amp_en || (rx_press && alert_cnt_q != 0)) begin
            pwm_cnt_q <= '0;
            spk_pwm   <= 1'b0;
        end else begin
            pwm_cnt_q <= (pwm_cnt_q >= PWM_DIV - 1) ? '0 : pwm_cnt_q + 32'd1;
            spk_pwm   <= (pwm_cnt_q < PWM_DIV / 2);
        end
    end

    // --------------------------------------------------
    // Assertions
    // --------------------------------------------------
    sequence s_ring;
        ring_hit && !(rx_press && alert_cnt_q != 0);
    endsequence

    a_ring_starts: assert property (@(posedge clk) disable iff (rst)
        s_ring |=> rx_led && amp_en) else $error("alert did not start");
    a_cancel_stop: assert property (@(posedge clk) disable iff (rst)
        rx_press && alert_cnt_q != 0 |=> !rx_led && !amp_en) else $error("cancel ignored");
    a_unarmed_deaf: assert property (@(posedge clk) disable iff (rst)
        !rx_armed && alert_cnt_q == 0 |=> !amp_en) else $error("alert before init");
    a_idle_led_off: assert property (@(posedge clk) disable iff (rst)
        alert_cnt_q == 0 && !$past(ring_hit) |-> !rx_led) else $error("led left on");
    a_pwm_gated: assert property (@(posedge clk) disable iff (rst)
        !amp_en |=> !spk_pwm) else $error("pwm while amp off");
    a_sleep_wake: assert property (@(posedge clk) disable iff (rst)
        tx_state_q == TX_SLEEP && !tx_press |=> tx_state_q == TX_SLEEP) else $error("woke without key");
    a_press_sends: assert property (@(posedge clk) disable iff (rst)
        tx_state_q == TX_SLEEP && tx_press |=> tx_msg.valid && tx_radio_pwr_en) else $error("no send");
    a_sleep_pwr: assert property (@(posedge clk) disable iff (rst)
        tx_state_q == TX_HOLD && !tx_lvl |=> !tx_radio_pwr_en) else $error("radio left powered");
    a_led_press: assert property (@(posedge clk) disable iff (rst)
        tx_press |=> tx_led) else $error("led not lit");
    a_led_release: assert property (@(posedge clk) disable iff (rst)
        tx_rel && !warn_led_q |=> !tx_led) else $error("led not off");
endmodule : doorbell_ctrl

// ==== bench/radio_model.sv ====
// Behavioural radio module facing the doorbell controller.
// Assumes the controller's clock and reset; messages travel as msg_s.
`timescale 1ns/1ps
module radio_model
    import doorbell_pkg::*;
#(
    parameter int unsigned INIT_CYC = 40
) (
    // Clock and reset.
    input  wire logic       clk,
    input  wire logic       rst,
    // Transmit path.
    input  msg_s            tx_msg,
    output logic            tx_send_done,
    // Receive path.
    input  wire logic       ring_req,
    input  wire logic [7:0] ring_code,
    input  wire logic       slow,
    output msg_s            rx_msg,
    output logic            init_done
);
    // ----------------------------------------
    // Start-up, send completion and delivery.
    // ----------------------------------------
    int unsigned init_q;
    int unsigned busy_q;
    always_ff @(posedge clk) begin
        if (rst) begin
            init_q       <= 0;
            busy_q       <= 0;
            tx_send_done <= 1'b0;
            rx_msg       <= '0;
        end else begin
            init_q       <= (init_q < INIT_CYC) ? init_q + 1 : init_q;
            busy_q       <= tx_msg.valid ? (slow ? 12 : 2) : ((busy_q > 0) ? busy_q - 1 : 0);
            tx_send_done <= (busy_q == 1);
            rx_msg       <= ring_req ? {1'b1, ring_code} : {1'b0, ~rx_msg.data};
        end
    end
    assign init_done = (init_q >= INIT_CYC);
endmodule : radio_model

// ==== bench/testbench.sv ====
// Self-checking bench for the doorbell controller and a radio model.
// Assumes shortened timing parameters; every wait is bounded.
`timescale 1ns/1ps
`define CHK(n, e, g) begin check_count++; if ((g) !== (e)) begin bad_count++; \
    $display("MISMATCH %s exp %0h got %0h", n, e, g); end end
module testbench;
    import doorbell_pkg::*;
    localparam int unsigned A = 100, B = 10, H = 50, P = 4;
    logic       clk = 0, rst = 1, tx_key = 0, batt = 0, rx_key = 0, ring_req = 0, slow = 0;
    logic [7:0] code = 8'h00, tx_data;
    logic       tx_led, pwr, done, awake, init, rx_led, spk, amp, armed;
    msg_s       tx_msg, rx_msg;
    int         seed = 28234, bad_count = 0, check_count = 0, i, k, d, h;
    int         n_tx = 0, n_rx = 0, n_pwm = 0, n_tl = 0;
    always #2 clk = ~clk;
    doorbell_ctrl #(.ALERT_CYC(A), .BLINK_CYC(B), .HOLD_CYC(H), .PWM_DIV(P)) uut (
        .clk(clk), .rst(rst), .tx_key_pin(tx_key), .batt_low_pin(batt), .tx_send_done(done),
        .tx_led(tx_led), .tx_radio_pwr_en(pwr), .tx_msg(tx_msg), .tx_awake(awake), .rx_key_pin(rx_key),
        .radio_init_done(init), .rx_msg(rx_msg), .rx_led(rx_led), .spk_pwm(spk), .amp_en(amp), .rx_armed(armed));
    radio_model #(.INIT_CYC(40)) radio (.clk(clk), .rst(rst), .tx_msg(tx_msg), .tx_send_done(done),
        .ring_req(ring_req), .ring_code(code), .slow(slow), .rx_msg(rx_msg), .init_done(init));
    // ----------------------------------------
    // Event counters.
    // ----------------------------------------
    always @(posedge clk) if (tx_msg.valid === 1'b1) begin n_tx++; tx_data = tx_msg.data; end
    always @(rx_led) n_rx++;
    always @(tx_led) n_tl++;
    always @(posedge spk) n_pwm++;
    // ----------------------------------------
    // Helpers.
    // ----------------------------------------
    function automatic int exp_sends(input int hold);
        return (hold >= H) ? 2 : 1;
    endfunction : exp_sends
    task automatic cyc(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask : cyc
    task automatic ring(input logic [7:0] c);
        code = c;
        ring_req = 1'b1;
        cyc(1);
        ring_req = 1'b0;
    endtask : ring
    task automatic final_report;
        $display("checks %0d mismatches %0d", check_count, bad_count);
        if (bad_count == 0 && check_count > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask : final_report
    initial begin
        repeat (20000) @(posedge clk);
        bad_count++;
        final_report();
    end
    // ----------------------------------------
    // Scenarios.
    // ----------------------------------------
    initial begin
        cyc(12);
        rst = 1'b0;
        `CHK("tx_awake", 1'b0, awake)
        ring(8'h5A);
        cyc(4);
        `CHK("rx_led_early", 1'b0, rx_led)
        for (i = 0; i < 60 && armed !== 1'b1; i++) cyc(1);
        `CHK("rx_armed", 1'b1, armed)
        for (k = 0; k < 4; k++) begin
            h = (k % 2) ? H + 20 : 5 + ($unsigned($random(seed)) % 30);
            slow = k[1];
            d = n_tx;
            tx_key = 1'b1;
            for (i = 0; i < 10 && tx_led !== 1'b1; i++) cyc(1);
            `CHK("tx_led_on", 1'b1, tx_led)
            `CHK("tx_pwr_on", 1'b1, pwr)
            cyc(h);
            `CHK("tx_awake_on", 1'b1, awake)
            tx_key = 1'b0;
            for (i = 0; i < 10 && tx_led !== 1'b0; i++) cyc(1);
            `CHK("tx_led_off", 1'b0, tx_led)
            cyc(15);
            `CHK("tx_pwr_off", 1'b0, pwr)
            `CHK("tx_asleep", 1'b0, awake)
            `CHK("tx_sends", exp_sends(h), n_tx - d)
            `CHK("tx_code", 8'h5A, tx_data)
        end
        ring(8'h5A);
        for (i = 0; i < 5 && rx_led !== 1'b1; i++) cyc(1);
        `CHK("amp_with_led", 1'b1, amp)
        d = n_rx;
        h = n_pwm;
        cyc(A - 10);
        `CHK("amp_held", 1'b1, amp)
        `CHK("pwm_active", 1'b1, (n_pwm - h) >= (A - 10) / P - 2)
        cyc(15);
        `CHK("rx_led_end", 1'b0, rx_led)
        `CHK("amp_end", 1'b0, amp)
        `CHK("rx_blinks", 1'b1, (n_rx - d) >= A / B - 2 && (n_rx - d) <= A / B + 1)
        h = n_pwm;
        cyc(10);
        `CHK("pwm_quiet", h, n_pwm)
        ring(8'h5A);
        cyc(5 + ($unsigned($random(seed)) % 40));
        rx_key = 1'b1;
        cyc(5);
        `CHK("cancel_led", 1'b0, rx_led)
        `CHK("cancel_amp", 1'b0, amp)
        `CHK("cancel_spk", 1'b0, spk)
        cyc(B);
        `CHK("cancel_led_hold", 1'b0, rx_led)
        `CHK("cancel_amp_hold", 1'b0, amp)
        rx_key = 1'b0;
        code = 8'($random(seed));
        ring((code == 8'h5A) ? 8'h00 : code);
        cyc(5);
        `CHK("bad_code", 1'b0, rx_led)
        batt = 1'b1;
        for (i = 0; i < 10 && tx_led !== 1'b1; i++) cyc(1);
        `CHK("batt_led", 1'b1, tx_led)
        d = n_tl;
        cyc(A + 10);
        `CHK("batt_end", 1'b0, tx_led)
        `CHK("batt_blinks", 1'b1, (n_tl - d) >= A / B - 2 && (n_tl - d) <= A / B + 1)
        batt = 1'b0;
        final_report();
    end
endmodule : testbench
